/* common/dcf_defines.svh */
// constants of the dual clock fifo: offsets, fields, reset values, counts
`ifndef DCF_DEFINES_SVH
`define DCF_DEFINES_SVH
`define DCF_DATA_W 18
`define DCF_DEPTH 64
`define DCF_PTR_MAX_W 13
`define DCF_OFS_W 12
`define DCF_APB_AW 12
`define DCF_REG_CTRL 12'h000
`define DCF_REG_AE_OFS 12'h004
`define DCF_REG_AF_OFS 12'h008
`define DCF_REG_STATUS 12'h00c
`define DCF_CTRL_ASYNC_BIT 0
`define DCF_CTRL_CASC_BIT 1
`define DCF_CTRL_RST 2'h0
`define DCF_AE_OFS_RST 12'h007
`define DCF_AF_OFS_RST 12'h007
`define DCF_STAT_FULL_BIT 16
`define DCF_STAT_HALF_BIT 17
`define DCF_STAT_TOKEN_BIT 18
`define DCF_INIT_CYCLES 2'h3
`endif

/* common/dcf_pkg.sv */
// types and pointer helpers of the dual clock fifo
`default_nettype none
`include "dcf_defines.svh"
package dcf_pkg;
   typedef logic [`DCF_DATA_W-1:0] dcf_word_t;
   typedef logic [`DCF_PTR_MAX_W-1:0] dcf_ptr_t;
   typedef logic [`DCF_PTR_MAX_W:0] dcf_cmp_t;
   typedef logic [`DCF_OFS_W-1:0] dcf_ofs_t;
   typedef enum logic [1:0] {DCF_TOK_INIT, DCF_TOK_WAIT, DCF_TOK_HELD} dcf_tok_t;

   function automatic dcf_ptr_t dcf_bin2gray(input dcf_ptr_t b);
      return b ^ (b >> 1);
   endfunction

   function automatic dcf_ptr_t dcf_gray2bin(input dcf_ptr_t g);
      dcf_ptr_t b;
      b = g;
      for (int i = `DCF_PTR_MAX_W - 2; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction
endpackage
`default_nettype wire

/* common/dcf_gray_if.sv */
// gray pointer carrier between a domain and its synchroniser
`default_nettype none
interface dcf_gray_if #(parameter int W = 7);
   logic [W-1:0] src;
   logic [W-1:0] dst;
   modport tx(output src, input dst);
   modport rx(input src, output dst);
endinterface
`default_nettype wire

/* rtl/dcf_gray_sync.sv */
// two stage synchroniser for a gray coded pointer
`default_nettype none
module dcf_gray_sync (
   // clock and reset of the receiving domain
   input wire logic clk,
   input wire logic rst_n,
   // pointer carrier
   dcf_gray_if.rx g
);
   logic [$bits(g.src)-1:0] stage1_reg;
   logic [$bits(g.src)-1:0] stage2_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1_reg <= '0;
         stage2_reg <= '0;
      end else begin
         stage1_reg <= g.src;
         stage2_reg <= stage1_reg;
      end
   end

   assign g.dst = stage2_reg;
endmodule
`default_nettype wire

/* rtl/dcf_top.sv */
// dual clock 18-bit fifo with flags, depth cascade and apb control
//------------------------------------------------------------
// Contract
// - write stores word each enabled non-full edge
// - data ports and entries are 18 bits
// - read enable gates every read effect
// - enabled non-empty read edge presents next word
// - works with shared or independent clocks
// - read and write same period, no interference
// - empty flag changes only on read clock
// - full flag changes only on write clock
// - synchronous flags stable between their edges
// - mode select picks sync or async almost flags
// - sync almost-empty on read, almost-full on write
// - five status outputs encode fill state
// - half-full shares chain output, cascade carries chain
// - chain output tells next device to take over
// - offset load writes offset register, not buffer
// - output enable high tristates data outputs
//------------------------------------------------------------
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`default_nettype none
`include "dcf_defines.svh"
module dcf_top
   import dcf_pkg::*;
#(
   parameter int DEPTH = `DCF_DEPTH
) (
   // clock and reset, pclk is also the write clock
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic [`DCF_APB_AW-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // write port
   input wire logic wr_en_n,
   input wire logic [`DCF_DATA_W-1:0] wr_data,
   input wire logic offset_load_n,
   // read port
   input wire logic rd_clk,
   input wire logic rd_en_n,
   input wire logic output_enable_n,
   output logic [`DCF_DATA_W-1:0] rd_data,
   output logic rd_data_oe,
   // status flags
   output logic empty_n,
   output logic full_n,
   output logic wr_chain_out_half_full_n,
   output logic almost_empty_n,
   output logic almost_full_n,
   // depth cascade
   input wire logic wr_chain_in_n,
   input wire logic rd_chain_in_n,
   input wire logic first_in_chain_n,
   output logic rd_chain_out_n
);
   localparam int AW = $clog2(DEPTH);
   localparam int PW = AW + 1;

   dcf_word_t mem_reg [DEPTH];
   dcf_gray_if #(.W(PW)) w2r ();
   dcf_gray_if #(.W(PW)) r2w ();

   //------------------------------------------------------------
   // apb registers
   //------------------------------------------------------------
   logic [1:0] ctrl_reg;
   dcf_ofs_t ae_ofs_reg;
   dcf_ofs_t af_ofs_reg;
   logic ofs_sel_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic [31:0] prdata_reg;
   logic [31:0] rd_value;
   logic addr_hit;
   logic apb_acc;
   logic apb_wr;
   logic ofs_load;
   logic [PW-1:0] wcount_reg;
   logic full_n_reg;
   logic hfo_reg;
   dcf_tok_t wtok_reg;

   assign apb_acc = psel && penable;
   assign apb_wr = apb_acc && pready_reg && pwrite;
   assign addr_hit = (paddr == `DCF_REG_CTRL) || (paddr == `DCF_REG_AE_OFS) ||
                     (paddr == `DCF_REG_AF_OFS) || (paddr == `DCF_REG_STATUS);
   assign ofs_load = !offset_load_n && !wr_en_n;

   always_comb begin
      case (paddr)
         `DCF_REG_CTRL: rd_value = {30'h0, ctrl_reg};
         `DCF_REG_AE_OFS: rd_value = {20'h0, ae_ofs_reg};
         `DCF_REG_AF_OFS: rd_value = {20'h0, af_ofs_reg};
         `DCF_REG_STATUS: rd_value = {13'h0, wtok_reg == DCF_TOK_HELD, !hfo_reg, !full_n_reg, 16'(wcount_reg)};
         default: rd_value = 32'h0;
      endcase
   end

   // one wait state: data and ready come from flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0;
      end else begin
         pready_reg <= apb_acc && !pready_reg;
         pslverr_reg <= apb_acc && !pready_reg && !addr_hit;
         if (apb_acc && !pready_reg) begin
            prdata_reg <= rd_value;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= `DCF_CTRL_RST;
      end else if (apb_wr && paddr == `DCF_REG_CTRL) begin
         ctrl_reg <= pwdata[1:0];
      end
   end

   // apb write to an offset register wins over a pin load in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ae_ofs_reg <= `DCF_AE_OFS_RST;
         af_ofs_reg <= `DCF_AF_OFS_RST;
         ofs_sel_reg <= 1'b0;
      end else if (apb_wr && paddr == `DCF_REG_AE_OFS) begin
         ae_ofs_reg <= pwdata[`DCF_OFS_W-1:0];
      end else if (apb_wr && paddr == `DCF_REG_AF_OFS) begin
         af_ofs_reg <= pwdata[`DCF_OFS_W-1:0];
      end else if (ofs_load) begin
         ofs_sel_reg <= !ofs_sel_reg;
         if (!ofs_sel_reg) begin
            ae_ofs_reg <= wr_data[`DCF_OFS_W-1:0];
         end else begin
            af_ofs_reg <= wr_data[`DCF_OFS_W-1:0];
         end
      end
   end

   //------------------------------------------------------------
   // write domain
   //------------------------------------------------------------
   logic [PW-1:0] wbin_reg;
   logic [PW-1:0] wgray_reg;
   logic [PW-1:0] wbin_next;
   logic [PW-1:0] wgray_next;
   logic [PW-1:0] rbin_w;
   logic [PW-1:0] wcount_next;
   dcf_ptr_t wg_full;
   dcf_ptr_t rb_full;
   logic wr_go;
   logic wr_ok;
   logic wr_pass;
   logic casc;
   logic af_sync_reg;
   logic ae_async_reg;
   logic [1:0] winit_reg;
   logic fl_s1_reg;
   logic fl_s2_reg;
   logic wci_s1_reg;
   logic wci_s2_reg;
   logic wci_s3_reg;

   assign casc = ctrl_reg[`DCF_CTRL_CASC_BIT];
   assign wr_ok = !casc || (wtok_reg == DCF_TOK_HELD);
   assign wr_go = !wr_en_n && full_n_reg && offset_load_n && wr_ok;
   assign wr_pass = wr_go && casc && (&wbin_reg[AW-1:0]);
   assign wbin_next = wbin_reg + PW'(wr_go);
   assign wg_full = dcf_bin2gray(dcf_ptr_t'(wbin_next));
   assign wgray_next = wg_full[PW-1:0];
   assign rb_full = dcf_gray2bin(dcf_ptr_t'(r2w.dst));
   assign rbin_w = rb_full[PW-1:0];
   assign wcount_next = wbin_next - rbin_w;
   assign w2r.src = wgray_reg;

   always_ff @(posedge pclk) begin
      if (wr_go) begin
         mem_reg[wbin_reg[AW-1:0]] <= wr_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wbin_reg <= '0;
         wgray_reg <= '0;
      end else begin
         wbin_reg <= wbin_next;
         wgray_reg <= wgray_next;
      end
   end

   // write-clock flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         full_n_reg <= 1'b1;
         wcount_reg <= '0;
         af_sync_reg <= 1'b1;
         ae_async_reg <= 1'b0;
         hfo_reg <= 1'b1;
      end else begin
         full_n_reg <= !(wgray_next == {~r2w.dst[PW-1:PW-2], r2w.dst[PW-3:0]});
         wcount_reg <= wcount_next;
         af_sync_reg <= !(dcf_cmp_t'(wcount_next) + dcf_cmp_t'(af_ofs_reg) >= dcf_cmp_t'(DEPTH));
         ae_async_reg <= !(dcf_cmp_t'(wcount_next) <= dcf_cmp_t'(ae_ofs_reg));
         hfo_reg <= casc ? !wr_pass : !(dcf_cmp_t'(wcount_next) > dcf_cmp_t'(DEPTH / 2));
      end
   end

   // strap and chain input capture
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fl_s1_reg <= 1'b1;
         fl_s2_reg <= 1'b1;
         wci_s1_reg <= 1'b1;
         wci_s2_reg <= 1'b1;
         wci_s3_reg <= 1'b1;
         winit_reg <= 2'h0;
      end else begin
         fl_s1_reg <= first_in_chain_n;
         fl_s2_reg <= fl_s1_reg;
         wci_s1_reg <= wr_chain_in_n;
         wci_s2_reg <= wci_s1_reg;
         wci_s3_reg <= wci_s2_reg;
         if (winit_reg != `DCF_INIT_CYCLES) begin
            winit_reg <= winit_reg + 2'h1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wtok_reg <= DCF_TOK_INIT;
      end else begin
         case (wtok_reg)
            DCF_TOK_INIT: begin
               if (winit_reg == `DCF_INIT_CYCLES) begin
                  wtok_reg <= fl_s2_reg ? DCF_TOK_WAIT : DCF_TOK_HELD;
               end
            end
            DCF_TOK_WAIT: begin
               if (!wci_s2_reg && wci_s3_reg) begin
                  wtok_reg <= DCF_TOK_HELD;
               end
            end
            DCF_TOK_HELD: begin
               if (wr_pass) begin
                  wtok_reg <= DCF_TOK_WAIT;
               end
            end
            default: wtok_reg <= DCF_TOK_INIT;
         endcase
      end
   end

   //------------------------------------------------------------
   // read domain
   //------------------------------------------------------------
   logic rrst_s1_reg;
   logic rd_rst_n_reg;
   logic [PW-1:0] rbin_reg;
   logic [PW-1:0] rgray_reg;
   logic [PW-1:0] rbin_next;
   logic [PW-1:0] rgray_next;
   logic [PW-1:0] wbin_r;
   logic [PW-1:0] rcount_next;
   dcf_ptr_t rg_full;
   dcf_ptr_t wb_full;
   logic rd_go;
   logic rd_ok;
   logic rd_pass;
   logic empty_n_reg;
   logic ae_sync_reg;
   logic af_async_reg;
   logic [`DCF_DATA_W-1:0] rd_data_reg;
   logic [`DCF_DATA_W-1:0] rd_word;
   logic oe_reg;
   logic rco_reg;
   logic [1:0] mode_s1_reg;
   logic [1:0] mode_s2_reg;
   dcf_ofs_t ae_s1_reg;
   dcf_ofs_t ae_s2_reg;
   dcf_ofs_t af_s1_reg;
   dcf_ofs_t af_s2_reg;
   logic [2:0] pin_s1_reg;
   logic [2:0] pin_s2_reg;
   logic rci_s3_reg;
   logic [1:0] rinit_reg;
   dcf_tok_t rtok_reg;

   always_ff @(posedge rd_clk or negedge presetn) begin
      if (!presetn) begin
         rrst_s1_reg <= 1'b0;
         rd_rst_n_reg <= 1'b0;
      end else begin
         rrst_s1_reg <= 1'b1;
         rd_rst_n_reg <= rrst_s1_reg;
      end
   end

   dcf_gray_sync u_w2r (.clk(rd_clk), .rst_n(rd_rst_n_reg), .g(w2r));
   dcf_gray_sync u_r2w (.clk(pclk), .rst_n(presetn), .g(r2w));

   assign rd_ok = !mode_s2_reg[`DCF_CTRL_CASC_BIT] || (rtok_reg == DCF_TOK_HELD);
   assign rd_go = !rd_en_n && empty_n_reg && rd_ok;
   assign rd_pass = rd_go && mode_s2_reg[`DCF_CTRL_CASC_BIT] && (&rbin_reg[AW-1:0]);
   assign rbin_next = rbin_reg + PW'(rd_go);
   assign rg_full = dcf_bin2gray(dcf_ptr_t'(rbin_next));
   assign rgray_next = rg_full[PW-1:0];
   assign wb_full = dcf_gray2bin(dcf_ptr_t'(w2r.dst));
   assign wbin_r = wb_full[PW-1:0];
   assign rcount_next = wbin_r - rbin_next;
   assign rd_word = mem_reg[rbin_reg[AW-1:0]];
   assign r2w.src = rgray_reg;

   // quasi-static settings and pins into the read domain
   always_ff @(posedge rd_clk or negedge rd_rst_n_reg) begin
      if (!rd_rst_n_reg) begin
         mode_s1_reg <= `DCF_CTRL_RST;
         mode_s2_reg <= `DCF_CTRL_RST;
         ae_s1_reg <= `DCF_AE_OFS_RST;
         ae_s2_reg <= `DCF_AE_OFS_RST;
         af_s1_reg <= `DCF_AF_OFS_RST;
         af_s2_reg <= `DCF_AF_OFS_RST;
         pin_s1_reg <= 3'h7;
         pin_s2_reg <= 3'h7;
         rci_s3_reg <= 1'b1;
         rinit_reg <= 2'h0;
      end else begin
         mode_s1_reg <= ctrl_reg;
         mode_s2_reg <= mode_s1_reg;
         ae_s1_reg <= ae_ofs_reg;
         ae_s2_reg <= ae_s1_reg;
         af_s1_reg <= af_ofs_reg;
         af_s2_reg <= af_s1_reg;
         pin_s1_reg <= {first_in_chain_n, rd_chain_in_n, output_enable_n};
         pin_s2_reg <= pin_s1_reg;
         rci_s3_reg <= pin_s2_reg[1];
         if (rinit_reg != `DCF_INIT_CYCLES) begin
            rinit_reg <= rinit_reg + 2'h1;
         end
      end
   end

   always_ff @(posedge rd_clk or negedge rd_rst_n_reg) begin
      if (!rd_rst_n_reg) begin
         rbin_reg <= '0;
         rgray_reg <= '0;
         empty_n_reg <= 1'b0;
         ae_sync_reg <= 1'b0;
         af_async_reg <= 1'b1;
         rd_data_reg <= '0;
         oe_reg <= 1'b0;
         rco_reg <= 1'b1;
      end else begin
         rbin_reg <= rbin_next;
         rgray_reg <= rgray_next;
         empty_n_reg <= !(rgray_next == w2r.dst);
         ae_sync_reg <= !(dcf_cmp_t'(rcount_next) <= dcf_cmp_t'(ae_s2_reg));
         af_async_reg <= !(dcf_cmp_t'(rcount_next) + dcf_cmp_t'(af_s2_reg) >= dcf_cmp_t'(DEPTH));
         if (rd_go) begin
            rd_data_reg <= rd_word;
         end
         oe_reg <= !pin_s2_reg[0];
         rco_reg <= !rd_pass;
      end
   end

   always_ff @(posedge rd_clk or negedge rd_rst_n_reg) begin
      if (!rd_rst_n_reg) begin
         rtok_reg <= DCF_TOK_INIT;
      end else begin
         case (rtok_reg)
            DCF_TOK_INIT: begin
               if (rinit_reg == `DCF_INIT_CYCLES) begin
                  rtok_reg <= pin_s2_reg[2] ? DCF_TOK_WAIT : DCF_TOK_HELD;
               end
            end
            DCF_TOK_WAIT: begin
               if (!pin_s2_reg[1] && rci_s3_reg) begin
                  rtok_reg <= DCF_TOK_HELD;
               end
            end
            DCF_TOK_HELD: begin
               if (rd_pass) begin
                  rtok_reg <= DCF_TOK_WAIT;
               end
            end
            default: rtok_reg <= DCF_TOK_INIT;
         endcase
      end
   end

   //------------------------------------------------------------
   // outputs
   //------------------------------------------------------------
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign rd_data = rd_data_reg;
   assign rd_data_oe = oe_reg;
   assign empty_n = empty_n_reg;
   assign full_n = full_n_reg;
   assign wr_chain_out_half_full_n = hfo_reg;
   assign rd_chain_out_n = rco_reg;
   assign almost_empty_n = ctrl_reg[`DCF_CTRL_ASYNC_BIT] ? ae_async_reg : ae_sync_reg;
   assign almost_full_n = ctrl_reg[`DCF_CTRL_ASYNC_BIT] ? af_async_reg : af_sync_reg;

   //------------------------------------------------------------
   // assertions
   //------------------------------------------------------------
   sequence s_chain_pulse;
      !hfo_reg ##1 hfo_reg;
   endsequence
   sequence s_apb_wait;
      pready_reg ##1 !pready_reg;
   endsequence

   property p_wr_store;
      @(posedge pclk) disable iff (!presetn) wr_go |=> (wbin_reg == $past(wbin_reg) + PW'(1));
   endproperty
   a_wr_store: assert property (p_wr_store) else $error("write did not advance pointer");

   property p_full_entry;
      @(posedge pclk) disable iff (!presetn) $fell(full_n_reg) |-> $past(wcount_next) == PW'(DEPTH);
   endproperty
   a_full_entry: assert property (p_full_entry) else $error("full flag set below depth");

   property p_empty_entry;
      @(posedge rd_clk) disable iff (!rd_rst_n_reg) $fell(empty_n_reg) |-> $past(rcount_next) == '0;
   endproperty
   a_empty_entry: assert property (p_empty_entry) else $error("empty flag set with data");

   property p_rd_word;
      @(posedge rd_clk) disable iff (!rd_rst_n_reg) rd_go |=> rd_data_reg == $past(rd_word);
   endproperty
   a_rd_word: assert property (p_rd_word) else $error("read word not presented");

   property p_rd_gated;
      @(posedge rd_clk) disable iff (!rd_rst_n_reg) rd_en_n |=> rbin_reg == $past(rbin_reg);
   endproperty
   a_rd_gated: assert property (p_rd_gated) else $error("read happened while disabled");

   property p_ofs_load;
      @(posedge pclk) disable iff (!presetn) ofs_load && !apb_wr |=> wbin_reg == $past(wbin_reg) &&
         (ae_ofs_reg == $past(wr_data[`DCF_OFS_W-1:0]) || af_ofs_reg == $past(wr_data[`DCF_OFS_W-1:0]));
   endproperty
   a_ofs_load: assert property (p_ofs_load) else $error("offset load misrouted");

   property p_oe;
      @(posedge rd_clk) disable iff (!rd_rst_n_reg) ##1 oe_reg == !$past(pin_s2_reg[0]);
   endproperty
   a_oe: assert property (p_oe) else $error("output enable mismatch");

   property p_empty_ae;
      @(posedge rd_clk) disable iff (!rd_rst_n_reg) !empty_n_reg && rcount_next == '0 |=> !ae_sync_reg;
   endproperty
   a_empty_ae: assert property (p_empty_ae) else $error("empty without almost empty");

   property p_chain_pass;
      @(posedge pclk) disable iff (!presetn) wr_pass |=> s_chain_pulse;
   endproperty
   a_chain_pass: assert property (p_chain_pass) else $error("chain pulse missing");

   property p_gray_step;
      @(posedge pclk) disable iff (!presetn) $countones(wgray_reg ^ $past(wgray_reg)) <= 1;
   endproperty
   a_gray_step: assert property (p_gray_step) else $error("write gray pointer jumped");

   property p_async_sel;
      @(posedge pclk) disable iff (!presetn) ctrl_reg[`DCF_CTRL_ASYNC_BIT] |->
         almost_empty_n == !(dcf_cmp_t'(wcount_reg) <= dcf_cmp_t'($past(ae_ofs_reg)));
   endproperty
   a_async_sel: assert property (p_async_sel) else $error("async flag mode not selected");

   property p_apb_ready;
      @(posedge pclk) disable iff (!presetn) apb_acc && !pready_reg |=> s_apb_wait;
   endproperty
   a_apb_ready: assert property (p_apb_ready) else $error("apb ready not one cycle");
endmodule
`default_nettype wire

/* verification/dcf_consumer.sv */
// read side consumer model of the dual clock fifo
`default_nettype none
module dcf_consumer
   import dcf_pkg::*;
(
   // read clock
   input wire logic rd_clk,
   // fifo read port
   input wire logic empty_n,
   input wire dcf_word_t rd_data,
   output var logic rd_en_n,
   // bench control
   input wire logic go,
   input wire logic slow
);
   timeunit 1ns;
   timeprecision 1ps;
   dcf_word_t got[$];
   logic pend = 1'b0;
   logic ph = 1'b0;
   initial rd_en_n = 1'b1;
   always @(posedge rd_clk) begin
      if (pend) begin
         got.push_back(rd_data);
      end
      pend <= !rd_en_n && empty_n === 1'b1;
      ph <= !ph;
      rd_en_n <= !(go && (!slow || ph));
   end
endmodule
`default_nettype wire

/* verification/dcf_top_tb.sv */
// self-checking bench of the dual clock fifo
`default_nettype none
module dcf_top_tb
   import dcf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DEPTH = 64;
   logic pclk = 0, rd_clk = 0, presetn = 0;
   logic [11:0] paddr = 0;
   logic psel = 0, penable = 0, pwrite = 0, pready, pslverr;
   logic [31:0] pwdata = 0, prdata;
   logic wr_en_n = 1, offset_load_n = 1, rd_en_n, output_enable_n = 1, rd_data_oe;
   dcf_word_t wr_data = 0, rd_data;
   logic empty_n, full_n, hf_n, ae_n, af_n, rco_n, go = 0, slow = 0;
   int num_errors = 0, n_compared = 0;
   int n_wlow = 0, n_rlow = 0, w_base = 0, r_base = 0;

   dcf_top #(.DEPTH(DEPTH)) u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .wr_en_n(wr_en_n), .wr_data(wr_data), .offset_load_n(offset_load_n),
      .rd_clk(rd_clk), .rd_en_n(rd_en_n), .output_enable_n(output_enable_n), .rd_data(rd_data),
      .rd_data_oe(rd_data_oe), .empty_n(empty_n), .full_n(full_n), .wr_chain_out_half_full_n(hf_n),
      .almost_empty_n(ae_n), .almost_full_n(af_n), .wr_chain_in_n(hf_n), .rd_chain_in_n(rco_n),
      .first_in_chain_n(1'b0), .rd_chain_out_n(rco_n));
   dcf_consumer u_cons (.rd_clk(rd_clk), .empty_n(empty_n), .rd_data(rd_data), .rd_en_n(rd_en_n),
      .go(go), .slow(slow));

   //------------------------------------------------
   // clocks and helpers
   //------------------------------------------------
   initial begin
      forever #2 pclk = ~pclk;
   end
   initial begin
      #1.3;
      forever #3 rd_clk = ~rd_clk;
   end

   // chain pulse counters, single device ring
   always @(posedge pclk) begin
      if (hf_n === 1'b0) n_wlow++;
   end
   always @(posedge rd_clk) begin
      if (rco_n === 1'b0) n_rlow++;
   end

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s exp %h got %h", nm, exp, got);
      end
   endtask

   // apb transfer, request held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp,
                      input logic err);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      if (!wr) chk("prdata", exp, prdata);
      chk("pslverr", {31'h0, err}, {31'h0, pslverr});
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr_words(input int n, input dcf_word_t base, input logic ld);
      for (int i = 0; i < n; i++) begin
         wr_en_n <= 1'b0;
         offset_load_n <= ld;
         wr_data <= base + dcf_word_t'(i);
         @(posedge pclk);
      end
      wr_en_n <= 1'b1;
      offset_load_n <= 1'b1;
   endtask

   task automatic wait_got(input int n);
      for (int i = 0; i < 3000 && u_cons.got.size() < n; i++) @(posedge pclk);
      chk("read count", n, u_cons.got.size());
   endtask

   task automatic chk_got(input int from, input int n, input dcf_word_t base);
      for (int i = 0; i < n; i++) chk("read word", base + dcf_word_t'(i), u_cons.got[from + i]);
   endtask

   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial begin
      #200000;
      num_errors++;
      complete_run();
   end

   //------------------------------------------------
   // tests
   //------------------------------------------------
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      repeat (8) @(posedge pclk);
      chk("empty_n", 0, empty_n);
      chk("full_n", 1, full_n);
      chk("rd_data_oe", 0, rd_data_oe);
      apb(0, 12'h000, 0, 0, 0);
      apb(0, 12'h004, 0, 7, 0);
      apb(0, 12'h008, 0, 7, 0);
      apb(0, 12'h010, 0, 0, 1);
      $display("test reset done");
      wr_words(2, 18'h3, 1'b0);
      repeat (10) @(posedge pclk);
      apb(0, 12'h004, 0, 3, 0);
      apb(0, 12'h008, 0, 4, 0);
      chk("empty_n", 0, empty_n);
      $display("test offset load done");
      output_enable_n <= 1'b0;
      go <= 1'b1;
      wr_words(20, 18'h100, 1'b1);
      wait_got(20);
      chk_got(0, 20, 18'h100);
      repeat (10) @(posedge pclk);
      chk("empty_n", 0, empty_n);
      chk("ae_n", 0, ae_n);
      chk("rd_data_oe", 1, rd_data_oe);
      $display("test stream done");
      go <= 1'b0;
      repeat (4) @(posedge pclk);
      wr_words(5, 18'h2aa00, 1'b1);
      repeat (20) @(posedge pclk);
      chk("empty_n", 1, empty_n);
      chk("ae_n", 1, ae_n);
      chk("read count", 20, u_cons.got.size());
      chk("rd_data", 18'h113, rd_data);
      $display("test gating done");
      wr_words(DEPTH, 18'h200, 1'b1);
      repeat (4) @(posedge pclk);
      chk("full_n", 0, full_n);
      chk("hf_n", 0, hf_n);
      chk("af_n", 0, af_n);
      apb(0, 12'h00c, 0, 32'h70040, 0);
      slow <= 1'b1;
      go <= 1'b1;
      wait_got(20 + DEPTH);
      chk_got(20, 5, 18'h2aa00);
      chk_got(25, DEPTH - 5, 18'h200);
      repeat (10) @(posedge pclk);
      chk("empty_n", 0, empty_n);
      chk("full_n", 1, full_n);
      $display("test full done");
      go <= 1'b0;
      apb(1, 12'h000, 1, 0, 0);
      apb(0, 12'h000, 0, 1, 0);
      wr_words(2, 18'h55, 1'b1);
      repeat (12) @(posedge pclk);
      chk("ae_n", 0, ae_n);
      chk("af_n", 1, af_n);
      chk("empty_n", 1, empty_n);
      $display("test async flags done");
      presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      repeat (8) @(posedge pclk);
      chk("empty_n", 0, empty_n);
      apb(0, 12'h00c, 0, 32'h40000, 0);
      apb(1, 12'h000, 2, 0, 0);
      w_base = n_wlow;
      r_base = n_rlow;
      wr_words(DEPTH, 18'h300, 1'b1);
      go <= 1'b1;
      wait_got(20 + 2 * DEPTH);
      chk_got(20 + DEPTH, DEPTH, 18'h300);
      repeat (10) @(posedge pclk);
      chk("wr chain pulses", w_base + 1, n_wlow);
      chk("rd chain pulses", r_base + 1, n_rlow);
      apb(0, 12'h00c, 0, 32'h40000, 0);
      $display("test cascade done");
      complete_run();
   end
endmodule
`default_nettype wire
